// >>> design/ssw_pkg.sv
// shared constants of the supply supervisor and watchdog
// assumes a single 100 MHz clock; all durations count its cycles
package ssw_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;

    // reset pulse length, nominal figure in milliseconds
    localparam int unsigned RESET_PULSE_LEN_MS = 300;
    localparam int unsigned RESET_PULSE_LEN_CYCLES = RESET_PULSE_LEN_MS * (CLK_HZ / 1000);

    // watchdog period, nominal figure in milliseconds
    localparam int unsigned WDOG_PERIOD_MS = 1600;
    localparam int unsigned WDOG_PERIOD_CYCLES = WDOG_PERIOD_MS * (CLK_HZ / 1000);

    // shortest kick level the host may hold, in nanoseconds (least time rounds up)
    localparam int unsigned KICK_MIN_NS = 50;
    localparam int unsigned KICK_MIN_CYCLES =
        (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // synchroniser depth and values taken under reset (safe side: in reset)
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic RST_SUPPLY_LOW = 1'b1;
    localparam logic RST_MANUAL_N = 1'b1;
    localparam logic RST_KICK = 1'b0;
    localparam logic RST_KICK_FLOAT = 1'b1;
    localparam logic RST_AUX_OK = 1'b1;

    // supervisor states, one-hot
    typedef enum logic [2:0] {
        ST_HOLD = 3'h1,
        ST_PULSE = 3'h2,
        ST_RUN = 3'h4
    } ssw_state_type;

endpackage

// >>> design/ssw_sync_if.sv
// carrier for the synchronised supervisor inputs
// driven by the synchroniser, read by the supervisor core
`timescale 1ns/10ps
interface ssw_sync_if;
    logic supply_low;
    logic manual_n;
    logic kick;
    logic kick_float;
    logic aux_ok;

    modport src (
        output supply_low,
        output manual_n,
        output kick,
        output kick_float,
        output aux_ok
    );

    modport dst (
        input supply_low,
        input manual_n,
        input kick,
        input kick_float,
        input aux_ok
    );
endinterface

// >>> design/ssw_sync.sv
// two-stage synchronisers for all pin inputs of the supervisor
// assumes pins are asynchronous to clk; outputs land on the carrier
`timescale 1ns/10ps
module ssw_sync (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // raw pins
    input wire logic supply_low_in,
    input wire logic manual_reset_n,
    input wire logic wdog_kick_in,
    input wire logic wdog_kick_float,
    input wire logic aux_monitor_in,
    // synchronised levels
    ssw_sync_if.src sync
);

    localparam logic [4:0] RST_VEC = {ssw_pkg::RST_SUPPLY_LOW, ssw_pkg::RST_MANUAL_N,
        ssw_pkg::RST_KICK, ssw_pkg::RST_KICK_FLOAT, ssw_pkg::RST_AUX_OK};

    logic [4:0] meta;
    logic [4:0] stable;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta <= RST_VEC;
            stable <= RST_VEC;
        end else if (clk_en) begin
            meta <= {supply_low_in, manual_reset_n, wdog_kick_in, wdog_kick_float,
                aux_monitor_in};
            stable <= meta;
        end
    end

    assign sync.supply_low = stable[4];
    assign sync.manual_n = stable[3];
    assign sync.kick = stable[2];
    assign sync.kick_float = stable[1];
    assign sync.aux_ok = stable[0];

endmodule

// >>> design/ssw_cycle_timer.sv
// cycle counter that flags the last cycle of a fixed span
// assumes clear and run come from logic on the same clock
`timescale 1ns/10ps
module ssw_cycle_timer #(
    parameter int unsigned LIMIT = 16
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // control
    input wire logic clear,
    input wire logic run,
    // status
    output logic done
);

    localparam int unsigned CW = (LIMIT > 1) ? $clog2(LIMIT) : 1;
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] count;

    // done marks the cycle in which the span completes
    assign done = run && !clear && (count == LAST);

    // clear beats run so a restart is always a full span
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
        end else if (clk_en) begin
            if (clear || done) begin
                count <= '0;
            end else if (run) begin
                count <= count + CW'(1);
            end
        end
    end

endmodule

// >>> design/ssw_supervisor.sv
// supply supervisor: reset pulse generator, watchdog, auxiliary fail flag
// assumes comparator results arrive as digital pin levels, asynchronous to clk
`timescale 1ns/10ps

module ssw_supervisor #(
    parameter int unsigned RESET_PULSE_CYCLES = ssw_pkg::RESET_PULSE_LEN_CYCLES,
    parameter int unsigned WDOG_CYCLES = ssw_pkg::WDOG_PERIOD_CYCLES
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // supply and manual reset
    input wire logic supply_low_in,
    input wire logic manual_reset_n,
    // watchdog kick from the host
    input wire logic wdog_kick_in,
    input wire logic wdog_kick_float,
    // auxiliary comparator, high while above reference
    input wire logic aux_monitor_in,
    // outputs to the host
    output logic reset_out_n,
    output logic wdog_expired_n,
    output logic aux_fail_n
);

    ssw_sync_if sync ();

    ssw_pkg::ssw_state_type state;
    ssw_pkg::ssw_state_type next_state;

    logic hold_req;
    logic in_reset;
    logic pulse_done;
    logic kick_prev;
    logic kick_edge;
    logic wdog_armed;
    logic wdog_clear;
    logic wdog_run;
    logic wdog_done;
    logic expired;

    // every pin passes two flops before use
    ssw_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .supply_low_in(supply_low_in),
        .manual_reset_n(manual_reset_n),
        .wdog_kick_in(wdog_kick_in),
        .wdog_kick_float(wdog_kick_float),
        .aux_monitor_in(aux_monitor_in),
        .sync(sync.src)
    );

    // conditions that hold reset low with no time limit
    assign hold_req = sync.supply_low || !sync.manual_n;

    // reset is active outside the run state only; no watchdog term here
    assign in_reset = (state != ssw_pkg::ST_RUN);

    // reset pulse length timer, cleared whenever a hold condition returns
    ssw_cycle_timer #(
        .LIMIT(RESET_PULSE_CYCLES)
    ) u_pulse (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(state != ssw_pkg::ST_PULSE),
        .run(state == ssw_pkg::ST_PULSE),
        .done(pulse_done)
    );

    // supervisor state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            ssw_pkg::ST_HOLD: begin
                // release of supply or manual reset starts the pulse
                if (!hold_req) begin
                    next_state = ssw_pkg::ST_PULSE;
                end
            end
            ssw_pkg::ST_PULSE: begin
                // a new hold restarts the whole pulse later, never shortens it
                if (hold_req) begin
                    next_state = ssw_pkg::ST_HOLD;
                end else if (pulse_done) begin
                    next_state = ssw_pkg::ST_RUN;
                end
            end
            ssw_pkg::ST_RUN: begin
                if (hold_req) begin
                    next_state = ssw_pkg::ST_HOLD;
                end
            end
            default: begin
                next_state = ssw_pkg::ST_HOLD;
            end
        endcase
    end

    // state register; power-on looks like a supply-low hold
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ssw_pkg::ST_HOLD;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // reset output follows the next state so it leaves with the pulse end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_out_n <= 1'b0;
        end else if (clk_en) begin
            reset_out_n <= (next_state == ssw_pkg::ST_RUN);
        end
    end

    // kick edge detect on the synchronised level, both directions count
    assign kick_edge = (sync.kick != kick_prev) && !sync.kick_float;

    // last sampled kick level; tracks during float so release gives no false edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            kick_prev <= ssw_pkg::RST_KICK;
        end else if (clk_en) begin
            kick_prev <= sync.kick;
        end
    end

    // watchdog stays idle until the first edge after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdog_armed <= 1'b0;
        end else if (clk_en) begin
            if (in_reset || sync.kick_float) begin
                wdog_armed <= 1'b0;
            end else if (kick_edge) begin
                wdog_armed <= 1'b1;
            end
        end
    end

    // any edge, active reset or float clears the count
    assign wdog_clear = in_reset || sync.kick_float || kick_edge;
    // counting stops once expired; the next edge restarts a full period
    assign wdog_run = wdog_armed && !expired;

    ssw_cycle_timer #(
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(wdog_clear),
        .run(wdog_run),
        .done(wdog_done)
    );

    // sticky timeout flag; kick edge clears it, and an edge in the last count cycle masks wdog_done so the edge wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            expired <= 1'b0;
        end else if (clk_en) begin
            if (in_reset || sync.kick_float) begin
                expired <= 1'b0;
            end else if (wdog_done) begin
                expired <= 1'b1;
            end else if (kick_edge) begin
                expired <= 1'b0;
            end
        end
    end

    // watchdog output: supply low forces it, no minimum low time applies
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdog_expired_n <= 1'b0;
        end else if (clk_en) begin
            wdog_expired_n <= !(sync.supply_low || expired);
        end
    end

    // auxiliary fail mirrors the comparator with no filtering
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aux_fail_n <= ssw_pkg::RST_AUX_OK;
        end else if (clk_en) begin
            aux_fail_n <= sync.aux_ok;
        end
    end

endmodule

// >>> verification/ssw_supervisor_asserts.sv
// port checker for the supervisor
// history checks restart after any clk_en low; bound into ssw_supervisor
`timescale 1ns/10ps
module ssw_supervisor_asserts #(
    parameter int unsigned RESET_PULSE_CYCLES = 20,
    parameter int unsigned WDOG_CYCLES = 50
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // pins in
    input wire logic supply_low_in,
    input wire logic manual_reset_n,
    input wire logic wdog_kick_in,
    input wire logic wdog_kick_float,
    input wire logic aux_monitor_in,
    // pins out
    input wire logic reset_out_n,
    input wire logic wdog_expired_n,
    input wire logic aux_fail_n
);
    logic [2:0] up;
    logic [9:0] quiet;
    logic [9:0] kquiet;
    logic kick_prev;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // cycles since release; pin history before it met reset-valued syncs
    always_ff @(posedge clk) begin
        if (!rst_b || !clk_en) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    // cycles since any reset cause at the pins
    always_ff @(posedge clk) begin
        if (!rst_b || supply_low_in || !manual_reset_n) quiet <= 10'h0;
        else if (quiet != 10'h3ff) quiet <= quiet + 10'h1;
    end
    // cycles since anything that restarts or clears the watchdog
    always_ff @(posedge clk) begin
        kick_prev <= wdog_kick_in;
        if (!rst_b || !reset_out_n || supply_low_in || !manual_reset_n || wdog_kick_float
            || wdog_kick_in != kick_prev) kquiet <= 10'h0;
        else if (kquiet != 10'h3ff) kquiet <= kquiet + 10'h1;
    end
    AST_AUX: assert property (up == 3'h7 |-> aux_fail_n == $past(aux_monitor_in, 3))
        else $error("aux fail flag off");
    AST_SUPPLY_RST: assert property (up == 3'h7 && $past(supply_low_in, 3)
        |-> !reset_out_n)
        else $error("reset high under low supply");
    AST_MANUAL: assert property (up == 3'h7 && !$past(manual_reset_n, 3)
        |-> !reset_out_n)
        else $error("reset high under manual reset");
    AST_SUPPLY_EXP: assert property ($past(supply_low_in, 3) && up == 3'h7
        |-> !wdog_expired_n)
        else $error("expired high under low supply");
    AST_PULSE: assert property ($rose(reset_out_n)
        |-> quiet >= RESET_PULSE_CYCLES && quiet <= RESET_PULSE_CYCLES + 5)
        else $error("reset pulse length off");
    AST_NO_WDOG_RST: assert property ($fell(reset_out_n) && up == 3'h7
        |-> $past(supply_low_in, 3) || !$past(manual_reset_n, 3))
        else $error("reset without cause");
    AST_PERIOD: assert property ($fell(wdog_expired_n)
        && !$past(supply_low_in, 3) && up == 3'h7
        |-> kquiet >= WDOG_CYCLES && kquiet <= WDOG_CYCLES + 8)
        else $error("watchdog period off");
    AST_EXP_HOLD: assert property (!wdog_expired_n && kquiet >= 10'h8
        |=> !wdog_expired_n)
        else $error("expired released without kick");
    AST_FLOAT: assert property (up == 3'h7 && $past(wdog_kick_float, 3)
        && $past(wdog_kick_float, 5) |-> wdog_expired_n == !$past(supply_low_in, 3))
        else $error("floating kick output off");
endmodule
bind ssw_supervisor ssw_supervisor_asserts #(
    .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES),
    .WDOG_CYCLES(WDOG_CYCLES)
) chk_u (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .supply_low_in(supply_low_in),
    .manual_reset_n(manual_reset_n), .wdog_kick_in(wdog_kick_in),
    .wdog_kick_float(wdog_kick_float), .aux_monitor_in(aux_monitor_in),
    .reset_out_n(reset_out_n), .wdog_expired_n(wdog_expired_n), .aux_fail_n(aux_fail_n)
);

// >>> verification/ssw_host_model.sv
// host model: kicks the watchdog or leaves its pin floating
// assumes mode changes land just after a rising edge
`timescale 1ns/10ps
module ssw_host_model #(
    parameter int unsigned GAP = 10
) (
    // clock and reset seen by the host
    input wire logic clk,
    input wire logic reset_out_n,
    // mode from the bench
    input wire logic kick_en,
    input wire logic float_en,
    // kick pin and its three-state flag
    output logic kick,
    output logic kick_float
);
    int unsigned cnt = 0;
    logic float_now;
    logic kick_now;
    initial begin
        kick = 1'b0;
        kick_float = 1'b0;
    end
    // modes taken at the edge, before the bench moves them, so no race with it
    // a released pin wanders every cycle, never a clean level
    // a driven pin toggles every GAP cycles, far inside the period
    always @(posedge clk) begin
        float_now = float_en;
        kick_now = kick_en;
        #1;
        kick_float = float_now;
        cnt = cnt + 1;
        if (float_now) begin
            kick = ~kick;
        end else if (kick_now && reset_out_n && cnt >= GAP) begin
            kick = ~kick;
            cnt = 0;
        end
    end
endmodule

// >>> verification/ssw_supervisor_tb.sv
// self-checking bench for the supervisor with a host model
// assumes shortened pulse and period parameters
`timescale 1ns/10ps
module ssw_supervisor_tb;
    localparam int unsigned RP = 20;
    localparam int unsigned WD = 50;
    localparam int unsigned GAP = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic supply_low_in = 1'b0;
    logic manual_reset_n = 1'b1;
    logic aux_monitor_in = 1'b1;
    logic kick_en = 1'b0;
    logic float_en = 1'b0;
    logic kick;
    logic kick_float;
    logic reset_out_n;
    logic wdog_expired_n;
    logic aux_fail_n;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    ssw_supervisor #(.RESET_PULSE_CYCLES(RP), .WDOG_CYCLES(WD)) dut_u (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .supply_low_in(supply_low_in),
        .manual_reset_n(manual_reset_n), .wdog_kick_in(kick), .wdog_kick_float(kick_float),
        .aux_monitor_in(aux_monitor_in), .reset_out_n(reset_out_n),
        .wdog_expired_n(wdog_expired_n), .aux_fail_n(aux_fail_n));
    ssw_host_model #(.GAP(GAP)) host_u (.clk(clk), .reset_out_n(reset_out_n),
        .kick_en(kick_en), .float_en(float_en), .kick(kick), .kick_float(kick_float));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    // bounded wait on an output level; 0 = reset, 1 = expired
    task automatic wait_lvl(input int which, input logic lvl, output int n);
        n = 0;
        while (((which == 0) ? reset_out_n : wdog_expired_n) !== lvl && n < 400) begin
            step(1);
            n++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_power_up;
        int n;
        wait_lvl(0, 1'b1, n);
        check("power-up pulse", 1'b1, n >= RP && n <= RP + 5);
        step(2 * WD);
        check("unarmed watchdog", 1'b1, wdog_expired_n);
    endtask
    // a low enable must freeze the synchronised levels
    task automatic t_aux;
        clk_en = 1'b0;
        aux_monitor_in = 1'b0;
        step(5);
        check("aux frozen", 1'b1, aux_fail_n);
        clk_en = 1'b1;
        step(3);
        check("aux fail low", 1'b0, aux_fail_n);
        aux_monitor_in = 1'b1;
        step(3);
        check("aux fail high", 1'b1, aux_fail_n);
    endtask
    task automatic t_manual;
        int n;
        manual_reset_n = 1'b0;
        step(3);
        check("manual reset", 1'b0, reset_out_n);
        step(30);
        check("manual held", 1'b0, reset_out_n);
        manual_reset_n = 1'b1;
        wait_lvl(0, 1'b1, n);
        check("manual pulse", 1'b1, n >= RP + 2 && n <= RP + 4);
    endtask
    // second dip lands mid-pulse, so the pulse must start over
    task automatic t_brownout;
        int n;
        supply_low_in = 1'b1;
        step(3);
        check("supply reset", 1'b0, reset_out_n);
        check("supply expired", 1'b0, wdog_expired_n);
        supply_low_in = 1'b0;
        step(3);
        check("expired released", 1'b1, wdog_expired_n);
        step(RP / 2);
        supply_low_in = 1'b1;
        step(4);
        supply_low_in = 1'b0;
        wait_lvl(0, 1'b1, n);
        check("pulse restarted", 1'b1, n >= RP + 2 && n <= RP + 4);
    endtask
    task automatic t_watchdog;
        int n;
        kick_en = 1'b1;
        step(3 * WD);
        check("kicked", 1'b1, wdog_expired_n);
        kick_en = 1'b0;
        wait_lvl(1, 1'b0, n);
        check("expiry time", 1'b1, n >= WD - GAP && n <= WD + 6);
        check("no reset on expiry", 1'b1, reset_out_n);
        step(2 * WD);
        check("expired held", 1'b0, wdog_expired_n);
        kick_en = 1'b1;
        wait_lvl(1, 1'b1, n);
        check("kick clears", 1'b1, n <= GAP + 5);
    endtask
    // kicks stop first: a float that failed to disarm would expire after release
    task automatic t_float;
        int n;
        kick_en = 1'b0;
        float_en = 1'b1;
        step(3 * WD);
        check("float disables", 1'b1, wdog_expired_n);
        float_en = 1'b0;
        step(2 * WD);
        check("float leaves watchdog idle", 1'b1, wdog_expired_n);
        float_en = 1'b1;
        supply_low_in = 1'b1;
        step(3);
        check("float shows supply", 1'b0, wdog_expired_n);
        supply_low_in = 1'b0;
        step(3);
        check("float shows recovery", 1'b1, wdog_expired_n);
        float_en = 1'b0;
        wait_lvl(0, 1'b1, n);
        check("supply pulse", 1'b1, n >= RP - 1 && n <= RP + 1);
    endtask
    // hang guard, well above the whole sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        step(2);
        rst_b = 1'b1;
        t_power_up();
        t_aux();
        t_manual();
        t_brownout();
        t_watchdog();
        t_float();
        report_and_stop();
    end
endmodule
